// ===== csfr_consts.svh
`ifndef CSFR_CONSTS_SVH
`define CSFR_CONSTS_SVH
// data memory map
`define CSFR_A_INDIRECT 8'h00
`define CSFR_A_POINTER 8'h01
`define CSFR_A_WORKING 8'h05
`define CSFR_A_PCLOW 8'h06
`define CSFR_A_TBL_LOW 8'h07
`define CSFR_A_TBL_HIGH 8'h08
`define CSFR_A_DOGSEL 8'h09
`define CSFR_A_STATUS 8'h0a
`define CSFR_A_IRQGATE 8'h0b
`define CSFR_A_CNT_HIGH 8'h0c
`define CSFR_A_CNT_LOW 8'h0d
`define CSFR_A_CNT_SETUP 8'h0e
`define CSFR_A_TBL_IDXH 8'h1f
`define CSFR_GP_BASE 8'h20
`define CSFR_GP_WORDS 96
// status bit positions
`define CSFR_ST_C 0
`define CSFR_ST_AC 1
`define CSFR_ST_Z 2
`define CSFR_ST_OV 3
`define CSFR_ST_HALT 4
`define CSFR_ST_DOG 5
`define CSFR_ST_WMASK 8'h0f
// irq gate bit positions
`define CSFR_IG_GATE 0
`define CSFR_IG_CNT_EN 2
`define CSFR_IG_CNT_FLAG 5
// count setup run bit
`define CSFR_CS_RUN 4
// divider select field width
`define CSFR_DOG_SEL_W 3
// reset values, interrupt vector and last table page
`define CSFR_RST_BYTE 8'h00
`define CSFR_RST_DOGSEL 8'h07
`define CSFR_IRQ_VECTOR 11'h008
`define CSFR_PAGE_LAST 3'h7
`endif

// ===== csfr_core.sv
/*
 special function register bank of an 8-bit core with general data memory.
 assumes one decoded instruction per cycle on req_in, held while stall_out
 is high, and a program rom that answers rom_addr_out within the same cycle.
*/
`include "csfr_consts.svh"
module csfr_core #(
    parameter int DOG_W = 8,
    parameter bit TBL_IDX_EN = 1'b1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // instruction side
    input wire csfr_pkg::csfr_req_t req_in,
    input wire logic [10:0] ret_pc_in,
    output logic stall_out,
    output logic [7:0] rdata_out,
    output logic [7:0] working_out,
    output logic [7:0] status_out,
    output logic [10:0] pc_out,
    // program rom
    output logic [10:0] rom_addr_out,
    input wire logic [14:0] rom_data_in,
    // events
    input wire logic count_tick_in,
    output logic irq_take_out,
    output logic [10:0] irq_ret_pc_out,
    output logic dog_reset_out
);
    typedef enum logic [1:0] {CSFR_IDLE, CSFR_DUMMY, CSFR_TABLE} csfr_state_t;

    csfr_state_t state_r;
    logic [7:0] gp_mem_r [`CSFR_GP_WORDS];
    logic [7:0] data_pointer_r;
    logic [7:0] working_register_r;
    logic [7:0] tbl_low_r;
    logic [6:0] table_word_high_byte_r;
    logic [7:0] table_index_high_r;
    logic [7:0] status_flags_r;
    logic [7:0] irq_gate_reg_r;
    logic [7:0] count_low_byte_r;
    logic [7:0] count_high_byte_r;
    logic [7:0] count_setup_reg_r;
    logic [7:0] dog_divider_select_r;
    logic [10:0] pc_r;
    logic [7:0] tbl_dest_r;
    logic [7:0] rdata_r;
    logic irq_take_r;
    logic [10:0] irq_ret_pc_r;
    logic dog_reset_r;
    logic stall_r;
    logic [6:0] dog_pre_r;
    logic [DOG_W-1:0] dog_cnt_r;

    csfr_pkg::csfr_op_t op;
    logic idle;
    logic irq_go;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] operand;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic alu_en;
    logic [7:0] alu_res;
    logic [3:0] alu_flags;
    logic [3:0] alu_fmask;
    logic [4:0] nib_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;
    logic [7:0] b_eff;
    logic cin;
    logic [15:0] count_nxt;
    logic count_ovf;
    logic [6:0] dog_mask;
    logic dog_tick;
    logic dog_ovf;

    assign op = req_in.op;
    assign idle = (state_r == CSFR_IDLE);
    // interrupt taken only with the global gate open
    assign irq_go = idle && irq_gate_reg_r[`CSFR_IG_GATE]
        && irq_gate_reg_r[`CSFR_IG_CNT_EN] && irq_gate_reg_r[`CSFR_IG_CNT_FLAG];

    // effective read address through the pointer
    assign rd_addr = (req_in.addr == `CSFR_A_INDIRECT) ? data_pointer_r : req_in.addr;

    always_comb
    begin
        rd_data = 8'h00;
        case (rd_addr)
            `CSFR_A_INDIRECT: rd_data = 8'h00;
            `CSFR_A_POINTER: rd_data = data_pointer_r;
            `CSFR_A_WORKING: rd_data = working_register_r;
            `CSFR_A_PCLOW: rd_data = pc_r[7:0];
            `CSFR_A_TBL_LOW: rd_data = tbl_low_r;
            `CSFR_A_TBL_HIGH: rd_data = {1'b0, table_word_high_byte_r};
            `CSFR_A_DOGSEL: rd_data = dog_divider_select_r;
            `CSFR_A_STATUS: rd_data = status_flags_r;
            `CSFR_A_IRQGATE: rd_data = irq_gate_reg_r;
            `CSFR_A_CNT_HIGH: rd_data = count_high_byte_r;
            `CSFR_A_CNT_LOW: rd_data = count_low_byte_r;
            `CSFR_A_CNT_SETUP: rd_data = count_setup_reg_r;
            `CSFR_A_TBL_IDXH: rd_data = table_index_high_r;
            default:
            begin
                if (rd_addr >= `CSFR_GP_BASE
                    && rd_addr < 8'(`CSFR_GP_BASE + `CSFR_GP_WORDS))
                begin
                    rd_data = gp_mem_r[7'(rd_addr - `CSFR_GP_BASE)];
                end
            end
        endcase
    end

    assign operand = req_in.use_imm ? req_in.imm : rd_data;

    // write path: store of working register, or table low byte
    always_comb
    begin
        wr_en = 1'b0;
        wr_addr = req_in.addr;
        wr_data = working_register_r;
        if (state_r == CSFR_TABLE)
        begin
            wr_en = 1'b1;
            wr_addr = tbl_dest_r;
            wr_data = rom_data_in[7:0];
        end
        else if (idle && !irq_go && op == csfr_pkg::CSFR_OP_MOV_MA)
        begin
            wr_en = 1'b1;
        end
        if (wr_addr == `CSFR_A_INDIRECT)
        begin
            wr_addr = data_pointer_r;
            if (data_pointer_r == `CSFR_A_INDIRECT)
            begin
                wr_en = 1'b0;
            end
        end
    end

    // alu: result always goes to the working register
    always_comb
    begin
        alu_en = idle && !irq_go;
        alu_res = working_register_r;
        alu_flags = 4'h0;
        alu_fmask = 4'h0;
        b_eff = operand;
        cin = 1'b0;
        if (op == csfr_pkg::CSFR_OP_SUB)
        begin
            b_eff = ~operand;
            cin = 1'b1;
        end
        nib_sum = {1'b0, working_register_r[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        low7_sum = {1'b0, working_register_r[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
        full_sum = {1'b0, working_register_r} + {1'b0, b_eff} + {8'h00, cin};
        case (op)
            csfr_pkg::CSFR_OP_MOV_AM: alu_res = operand;
            csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_SUB:
            begin
                alu_res = full_sum[7:0];
                alu_fmask = 4'hf;
                alu_flags[`CSFR_ST_C] = full_sum[8];
                alu_flags[`CSFR_ST_AC] = nib_sum[4];
                alu_flags[`CSFR_ST_OV] = low7_sum[7] ^ full_sum[8];
            end
            csfr_pkg::CSFR_OP_AND: alu_res = working_register_r & operand;
            csfr_pkg::CSFR_OP_OR: alu_res = working_register_r | operand;
            csfr_pkg::CSFR_OP_XOR: alu_res = working_register_r ^ operand;
            csfr_pkg::CSFR_OP_RLC:
            begin
                alu_res = {working_register_r[6:0], status_flags_r[`CSFR_ST_C]};
                alu_flags[`CSFR_ST_C] = working_register_r[7];
                alu_fmask[`CSFR_ST_C] = 1'b1;
            end
            csfr_pkg::CSFR_OP_RRC:
            begin
                alu_res = {status_flags_r[`CSFR_ST_C], working_register_r[7:1]};
                alu_flags[`CSFR_ST_C] = working_register_r[0];
                alu_fmask[`CSFR_ST_C] = 1'b1;
            end
            default: alu_en = 1'b0;
        endcase
        if (op == csfr_pkg::CSFR_OP_ADD || op == csfr_pkg::CSFR_OP_SUB
            || op == csfr_pkg::CSFR_OP_AND || op == csfr_pkg::CSFR_OP_OR
            || op == csfr_pkg::CSFR_OP_XOR)
        begin
            alu_flags[`CSFR_ST_Z] = (alu_res == 8'h00);
            alu_fmask[`CSFR_ST_Z] = 1'b1;
        end
    end

    // sequencing, program counter and table fetch
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= CSFR_IDLE;
            pc_r <= 11'h000;
            rom_addr_out <= 11'h000;
            tbl_dest_r <= `CSFR_RST_BYTE;
            irq_take_r <= 1'b0;
            irq_ret_pc_r <= 11'h000;
            stall_r <= 1'b0;
        end
        else
        begin
            irq_take_r <= 1'b0;
            stall_r <= 1'b0;
            case (state_r)
                CSFR_IDLE:
                begin
                    if (irq_go)
                    begin
                        irq_take_r <= 1'b1;
                        irq_ret_pc_r <= pc_r;
                        pc_r <= `CSFR_IRQ_VECTOR;
                    end
                    else if (wr_en && wr_addr == `CSFR_A_PCLOW)
                    begin
                        pc_r <= {pc_r[10:8], wr_data};
                        state_r <= CSFR_DUMMY;
                        stall_r <= 1'b1;
                    end
                    else if (op == csfr_pkg::CSFR_OP_TBL_PAGE)
                    begin
                        rom_addr_out <= {TBL_IDX_EN ? table_index_high_r[2:0]
                            : pc_r[10:8], tbl_low_r};
                        stall_r <= 1'b1;
                        tbl_dest_r <= req_in.addr;
                        pc_r <= pc_r + 11'h001;
                        state_r <= CSFR_TABLE;
                    end
                    else if (op == csfr_pkg::CSFR_OP_TBL_LAST)
                    begin
                        rom_addr_out <= {`CSFR_PAGE_LAST, tbl_low_r};
                        stall_r <= 1'b1;
                        tbl_dest_r <= req_in.addr;
                        pc_r <= pc_r + 11'h001;
                        state_r <= CSFR_TABLE;
                    end
                    else if (op == csfr_pkg::CSFR_OP_IRQ_RETURN)
                    begin
                        pc_r <= ret_pc_in;
                    end
                    else if (op != csfr_pkg::CSFR_OP_NOP)
                    begin
                        pc_r <= pc_r + 11'h001;
                    end
                end
                CSFR_DUMMY: state_r <= CSFR_IDLE;
                CSFR_TABLE: state_r <= CSFR_IDLE;
                default: state_r <= CSFR_IDLE;
            endcase
        end
    end

    // general purpose memory
    always_ff @(posedge mclk_in)
    begin
        if (wr_en && wr_addr >= `CSFR_GP_BASE
            && wr_addr < 8'(`CSFR_GP_BASE + `CSFR_GP_WORDS))
        begin
            gp_mem_r[7'(wr_addr - `CSFR_GP_BASE)] <= wr_data;
        end
    end

    // plain storage registers
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            data_pointer_r <= `CSFR_RST_BYTE;
            tbl_low_r <= `CSFR_RST_BYTE;
            table_index_high_r <= `CSFR_RST_BYTE;
            count_setup_reg_r <= `CSFR_RST_BYTE;
            dog_divider_select_r <= `CSFR_RST_DOGSEL;
            table_word_high_byte_r <= 7'h00;
        end
        else
        begin
            if (wr_en)
            begin
                case (wr_addr)
                    `CSFR_A_POINTER: data_pointer_r <= wr_data;
                    `CSFR_A_TBL_LOW: tbl_low_r <= wr_data;
                    `CSFR_A_TBL_IDXH: table_index_high_r <= wr_data;
                    `CSFR_A_CNT_SETUP: count_setup_reg_r <= wr_data;
                    `CSFR_A_DOGSEL: dog_divider_select_r <= wr_data;
                    default: ;
                endcase
            end
            if (state_r == CSFR_TABLE)
            begin
                table_word_high_byte_r <= rom_data_in[14:8];
            end
        end
    end

    // working register
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            working_register_r <= `CSFR_RST_BYTE;
        end
        else if (wr_en && wr_addr == `CSFR_A_WORKING)
        begin
            working_register_r <= wr_data;
        end
        else if (alu_en)
        begin
            working_register_r <= alu_res;
        end
    end

    // status flags
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            status_flags_r <= `CSFR_RST_BYTE;
        end
        else
        begin
            if (wr_en && wr_addr == `CSFR_A_STATUS)
            begin
                status_flags_r[3:0] <= 4'(wr_data & `CSFR_ST_WMASK);
            end
            else if (alu_en)
            begin
                status_flags_r[3:0] <= (status_flags_r[3:0] & ~alu_fmask)
                    | (alu_flags & alu_fmask);
            end
            if (idle && !irq_go && op == csfr_pkg::CSFR_OP_DOG_REFRESH)
            begin
                status_flags_r[`CSFR_ST_HALT] <= 1'b0;
                status_flags_r[`CSFR_ST_DOG] <= 1'b0;
            end
            if (idle && !irq_go && op == csfr_pkg::CSFR_OP_HALT)
            begin
                status_flags_r[`CSFR_ST_HALT] <= 1'b1;
                status_flags_r[`CSFR_ST_DOG] <= 1'b0;
            end
            if (dog_ovf)
            begin
                status_flags_r[`CSFR_ST_DOG] <= 1'b1;
            end
        end
    end

    // interrupt gate register
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            irq_gate_reg_r <= `CSFR_RST_BYTE;
        end
        else
        begin
            if (wr_en && wr_addr == `CSFR_A_IRQGATE)
            begin
                irq_gate_reg_r <= wr_data;
            end
            if (irq_go)
            begin
                irq_gate_reg_r[`CSFR_IG_GATE] <= 1'b0;
                irq_gate_reg_r[`CSFR_IG_CNT_FLAG] <= 1'b0;
            end
            else if (idle && op == csfr_pkg::CSFR_OP_IRQ_RETURN)
            begin
                irq_gate_reg_r[`CSFR_IG_GATE] <= 1'b1;
            end
            if (count_ovf)
            begin
                irq_gate_reg_r[`CSFR_IG_CNT_FLAG] <= 1'b1;
            end
        end
    end

    // 16-bit up counter
    assign count_nxt = {count_high_byte_r, count_low_byte_r} + 16'h0001;
    assign count_ovf = count_tick_in && count_setup_reg_r[`CSFR_CS_RUN]
        && ({count_high_byte_r, count_low_byte_r} == 16'hffff);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            count_low_byte_r <= `CSFR_RST_BYTE;
            count_high_byte_r <= `CSFR_RST_BYTE;
        end
        else if (wr_en && wr_addr == `CSFR_A_CNT_LOW)
        begin
            count_low_byte_r <= wr_data;
        end
        else if (wr_en && wr_addr == `CSFR_A_CNT_HIGH)
        begin
            count_high_byte_r <= wr_data;
        end
        else if (count_tick_in && count_setup_reg_r[`CSFR_CS_RUN])
        begin
            {count_high_byte_r, count_low_byte_r} <= count_nxt;
        end
    end

    // watchdog divider and counter
    assign dog_mask = 7'((8'h01 << dog_divider_select_r[`CSFR_DOG_SEL_W-1:0]) - 8'h01);
    assign dog_tick = ((dog_pre_r & dog_mask) == dog_mask);
    assign dog_ovf = dog_tick && (dog_cnt_r == {DOG_W{1'b1}});

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            dog_pre_r <= 7'h00;
            dog_cnt_r <= '0;
            dog_reset_r <= 1'b0;
        end
        else
        begin
            dog_pre_r <= dog_pre_r + 7'h01;
            dog_reset_r <= dog_ovf;
            if (idle && !irq_go && (op == csfr_pkg::CSFR_OP_DOG_REFRESH
                || op == csfr_pkg::CSFR_OP_HALT))
            begin
                dog_cnt_r <= '0;
                dog_pre_r <= 7'h00;
            end
            else if (dog_tick)
            begin
                dog_cnt_r <= dog_cnt_r + DOG_W'(1);
            end
        end
    end

    // registered read data
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            rdata_r <= 8'h00;
        end
        else if (idle && !irq_go && op == csfr_pkg::CSFR_OP_READ)
        begin
            rdata_r <= rd_data;
        end
    end

    assign stall_out = stall_r;
    assign rdata_out = rdata_r;
    assign working_out = working_register_r;
    assign status_out = status_flags_r;
    assign pc_out = pc_r;
    assign irq_take_out = irq_take_r;
    assign irq_ret_pc_out = irq_ret_pc_r;
    assign dog_reset_out = dog_reset_r;
endmodule

// ===== csfr_core_asserts.sv
/*
 port assertions for csfr_core.
 assumes it is bound to every csfr_core instance.
*/
`include "csfr_consts.svh"
module csfr_core_chk (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // instruction side
    input wire csfr_pkg::csfr_req_t req_in,
    input wire logic [10:0] ret_pc_in,
    input wire logic stall_out,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] working_out,
    input wire logic [7:0] status_out,
    input wire logic [10:0] pc_out,
    // program rom
    input wire logic [10:0] rom_addr_out,
    input wire logic [14:0] rom_data_in,
    // events
    input wire logic count_tick_in,
    input wire logic irq_take_out,
    input wire logic [10:0] irq_ret_pc_out,
    input wire logic dog_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk;
    csfr_pkg::csfr_op_t op;
    assign tk = !stall_out;
    assign op = req_in.op;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    AST_PCL_DUMMY: assert property (tk && op == csfr_pkg::CSFR_OP_MOV_MA
        && req_in.addr == `CSFR_A_PCLOW |=> stall_out ##1 !stall_out)
        else $error("pc low write without one dummy cycle");
    AST_PCL_JUMP: assert property (tk && op == csfr_pkg::CSFR_OP_MOV_MA
        && req_in.addr == `CSFR_A_PCLOW
        |=> pc_out == {$past(pc_out[10:8]), $past(working_out)})
        else $error("pc low write changed the page");
    AST_ADD_FLAGS: assert property (tk && op == csfr_pkg::CSFR_OP_ADD && req_in.use_imm
        |=> {status_out[0], working_out} == {1'b0, $past(working_out)}
        + {1'b0, $past(req_in.imm)})
        else $error("add result or carry wrong");
    AST_AND_ZERO: assert property (tk && op == csfr_pkg::CSFR_OP_AND && req_in.use_imm
        |=> working_out == ($past(working_out) & $past(req_in.imm))
        && status_out[2] == (working_out == 8'h00))
        else $error("and result or zero flag wrong");
    AST_STATUS_WR: assert property (tk && op == csfr_pkg::CSFR_OP_MOV_MA
        && req_in.addr == `CSFR_A_STATUS
        |=> status_out == {$past(status_out[7:6]), $past(status_out[5]) || dog_reset_out,
        $past(status_out[4]), $past(working_out[3:0])})
        else $error("status write touched system flags");
    AST_HALT_SET: assert property (tk && op == csfr_pkg::CSFR_OP_HALT
        |=> status_out[4])
        else $error("halt flag not set");
    AST_REFRESH_CLR: assert property (tk && op == csfr_pkg::CSFR_OP_DOG_REFRESH
        |=> !status_out[4] && (!status_out[5] || dog_reset_out))
        else $error("refresh left a system flag set");
    AST_TBL_LAST: assert property (tk && op == csfr_pkg::CSFR_OP_TBL_LAST
        |=> stall_out && rom_addr_out[10:8] == `CSFR_PAGE_LAST)
        else $error("last page fetch address wrong");
    AST_UNUSED_ZERO: assert property (tk && op == csfr_pkg::CSFR_OP_READ
        && req_in.addr inside {[8'h02:8'h04], [8'h0f:8'h1e]} |=> rdata_out == 8'h00)
        else $error("unused location read nonzero");
    AST_IRQ_ENTRY: assert property (irq_take_out
        |-> pc_out == `CSFR_IRQ_VECTOR ##1 !irq_take_out)
        else $error("interrupt entry wrong");
    AST_DOG_PULSE: assert property (dog_reset_out |=> !dog_reset_out)
        else $error("watchdog reset pulse too long");
endmodule

bind csfr_core csfr_core_chk csfr_core_chk_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .req_in(req_in), .ret_pc_in(ret_pc_in), .stall_out(stall_out), .rdata_out(rdata_out),
    .working_out(working_out), .status_out(status_out), .pc_out(pc_out),
    .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in), .count_tick_in(count_tick_in),
    .irq_take_out(irq_take_out), .irq_ret_pc_out(irq_ret_pc_out),
    .dog_reset_out(dog_reset_out));

// ===== csfr_core_test.sv
/*
 self-checking bench for csfr_core.
 assumes csfr_core_asserts.sv is compiled alongside.
*/
`include "csfr_consts.svh"
module csfr_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DW = 6;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tick = 1'b0;
    logic stall, irq, dogr;
    logic [10:0] ret_pc = 11'h123;
    logic [10:0] pc, rom_a, rpc;
    logic [7:0] rd, acc, st;
    logic [14:0] rom;
    csfr_pkg::csfr_req_t req = '0;
    int n_errors = 0;
    int check_count = 0;
    int seed = 44;
    int nirq = 0;
    always #25 clk = ~clk;
    assign rom = {rom_a[6:0] ^ 7'h55, rom_a[7:0] ^ 8'ha5};
    always @(posedge clk) if (irq === 1'b1) nirq++;
    csfr_core #(.DOG_W(DW), .TBL_IDX_EN(1'b1)) csfr_core_i (.mclk_in(clk), .rst_b_in(rst_b),
        .req_in(req), .ret_pc_in(ret_pc), .stall_out(stall), .rdata_out(rd),
        .working_out(acc), .status_out(st), .pc_out(pc), .rom_addr_out(rom_a),
        .rom_data_in(rom), .count_tick_in(tick), .irq_take_out(irq), .irq_ret_pc_out(rpc),
        .dog_reset_out(dogr));
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // present one request, hold it until taken, then idle
    task automatic issue(input csfr_pkg::csfr_op_t op, input logic [7:0] a, input logic [7:0] i);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{op, a, i, a == 8'h00};
        @(negedge clk);
        while (stall !== 1'b0 && n < 9)
        begin
            n++;
            @(negedge clk);
        end
        @(posedge clk);
        req <= '{csfr_pkg::CSFR_OP_NOP, 8'h00, 8'h00, 1'b0};
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        issue(csfr_pkg::CSFR_OP_MOV_AM, 8'h00, v);
        issue(csfr_pkg::CSFR_OP_MOV_MA, a, 8'h00);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        issue(csfr_pkg::CSFR_OP_READ, a, 8'h00);
        check(rd, e);
    endtask
    // {ov, z, ac, c, result}; k: 0 add 1 sub 2 and 3 or 4 xor
    function automatic logic [11:0] alu(input int k, input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic h;
        logic v;
        s = k[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        h = k[0] ? a[3:0] >= b[3:0] : {1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f;
        v = (a[7] ^ b[7] ^ ~k[0]) & (s[7] ^ a[7]);
        s = (k == 2) ? {1'b0, a & b} : (k == 3) ? {1'b0, a | b} : (k == 4) ? {1'b0, a ^ b} : s;
        return {v, s[7:0] == 8'h00, h, k[0] ^ s[8], s[7:0]};
    endfunction
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
    initial
    begin
        logic [7:0] x, y;
        logic [11:0] e;
        int v, w;
        static logic [7:0] ua[5] = '{8'h02, 8'h03, 8'h04, 8'h0f, 8'h1e};
        static csfr_pkg::csfr_op_t ops[5] = '{csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_SUB,
            csfr_pkg::CSFR_OP_AND, csfr_pkg::CSFR_OP_OR, csfr_pkg::CSFR_OP_XOR};
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        check(st[5:4], 0);
        rdc(`CSFR_A_DOGSEL, `CSFR_RST_DOGSEL);
        foreach (ua[i])
        begin
            wr(ua[i], 8'h5a);
            rdc(ua[i], 8'h00);
        end
        for (int i = 0; i < 16; i++)
        begin
            x = 8'h20 + 8'($unsigned($random(seed)) % 96);
            y = 8'($random(seed));
            wr(`CSFR_A_POINTER, x);
            wr(`CSFR_A_INDIRECT, y);
            rdc(x, y);
            rdc(`CSFR_A_POINTER, x);
            rdc(`CSFR_A_INDIRECT, y);
        end
        wr(`CSFR_A_POINTER, 8'h00);
        wr(`CSFR_A_INDIRECT, 8'h77);
        rdc(`CSFR_A_INDIRECT, 8'h00);
        rdc(`CSFR_A_POINTER, 8'h00);
        for (int i = 0; i < 30; i++)
        begin
            x = (i < 5) ? 8'h80 : 8'($random(seed));
            y = (i < 5) ? 8'h80 : 8'($random(seed));
            wr(8'h40, y);
            issue(csfr_pkg::CSFR_OP_MOV_AM, 8'h00, x);
            issue(ops[i % 5], (i < 15) ? 8'h00 : 8'h40, y);
            e = alu(i % 5, x, y);
            check(acc, e[7:0]);
            check(st[2], e[10]);
            if (i % 5 < 2)
                check(st[3:0], e[11:8]);
        end
        issue(csfr_pkg::CSFR_OP_MOV_AM, 8'h00, 8'hff);
        issue(csfr_pkg::CSFR_OP_ADD, 8'h00, 8'h01);
        issue(csfr_pkg::CSFR_OP_MOV_AM, 8'h00, 8'h81);
        issue(csfr_pkg::CSFR_OP_RLC, 8'h00, 8'h00);
        check({st[0], acc}, 9'h103);
        issue(csfr_pkg::CSFR_OP_RRC, 8'h00, 8'h00);
        check({st[0], acc}, 9'h181);
        wr(`CSFR_A_STATUS, 8'hff);
        check(st, 8'h0f);
        issue(csfr_pkg::CSFR_OP_HALT, 8'h00, 8'h00);
        check(st[4], 1'b1);
        wr(`CSFR_A_STATUS, 8'h00);
        check(st, 8'h10);
        issue(csfr_pkg::CSFR_OP_DOG_REFRESH, 8'h00, 8'h00);
        check(st[5:4], 2'b00);
        issue(csfr_pkg::CSFR_OP_MOV_AM, 8'h00, 8'h34);
        issue(csfr_pkg::CSFR_OP_MOV_MA, `CSFR_A_PCLOW, 8'h00);
        check(stall, 1'b1);
        check(pc[7:0], 8'h34);
        wr(`CSFR_A_TBL_LOW, 8'h3c);
        wr(`CSFR_A_TBL_IDXH, 8'h05);
        issue(csfr_pkg::CSFR_OP_TBL_PAGE, 8'h21, 8'h00);
        check(rom_a, 11'h53c);
        rdc(8'h21, 8'h3c ^ 8'ha5);
        issue(csfr_pkg::CSFR_OP_TBL_LAST, 8'h22, 8'h00);
        check(rom_a, 11'h73c);
        wr(`CSFR_A_TBL_HIGH, 8'h00);
        rdc(`CSFR_A_TBL_HIGH, {1'b0, 7'h3c ^ 7'h55});
        wr(`CSFR_A_CNT_LOW, 8'hfe);
        wr(`CSFR_A_CNT_HIGH, 8'hff);
        rdc(`CSFR_A_CNT_LOW, 8'hfe);
        rdc(`CSFR_A_CNT_HIGH, 8'hff);
        wr(`CSFR_A_IRQGATE, 8'h04);
        wr(`CSFR_A_CNT_SETUP, 8'h10);
        @(posedge clk);
        tick <= 1'b1;
        repeat (3) @(posedge clk);
        tick <= 1'b0;
        rdc(`CSFR_A_CNT_LOW, 8'h01);
        rdc(`CSFR_A_IRQGATE, 8'h24);
        check(11'(nirq), 11'h000);
        wr(`CSFR_A_IRQGATE, 8'h25);
        x = st;
        e = {1'b0, pc};
        for (w = 0; nirq == 0 && w < 20; w++) @(negedge clk);
        check(11'(nirq), 11'h001);
        check(pc, `CSFR_IRQ_VECTOR);
        check(st, x);
        check(rpc, e[10:0]);
        issue(csfr_pkg::CSFR_OP_READ, `CSFR_A_IRQGATE, 8'h00);
        check(rd[0], 1'b0);
        wr(`CSFR_A_IRQGATE, 8'h04);
        issue(csfr_pkg::CSFR_OP_IRQ_RETURN, 8'h00, 8'h00);
        check(pc, 11'h123);
        rdc(`CSFR_A_IRQGATE, 8'h05);
        for (int a = 0; a < 2; a++)
        begin
            wr(`CSFR_A_DOGSEL, 8'h08 | 8'(a));
            issue(csfr_pkg::CSFR_OP_DOG_REFRESH, 8'h00, 8'h00);
            for (v = 0; dogr !== 1'b1 && v < 1000; v++) @(negedge clk);
            w = (1 << DW) << a;
            check(11'(v > w - 4 && v < w + (1 << a) + 6), 11'h001);
            repeat (3) @(negedge clk);
            check(st[5], 1'b1);
        end
        issue(csfr_pkg::CSFR_OP_HALT, 8'h00, 8'h00);
        check(st[5:4], 2'b01);
        test_done();
    end
endmodule

// ===== csfr_pkg.sv
/*
 types shared by the special function register bank.
 takes no numbers from csfr_consts.svh; its widths are written as literals.
*/
package csfr_pkg;
    typedef enum logic [4:0] {
        CSFR_OP_NOP,
        CSFR_OP_READ,
        CSFR_OP_MOV_MA,
        CSFR_OP_MOV_AM,
        CSFR_OP_ADD,
        CSFR_OP_SUB,
        CSFR_OP_AND,
        CSFR_OP_OR,
        CSFR_OP_XOR,
        CSFR_OP_RLC,
        CSFR_OP_RRC,
        CSFR_OP_TBL_PAGE,
        CSFR_OP_TBL_LAST,
        CSFR_OP_HALT,
        CSFR_OP_DOG_REFRESH,
        CSFR_OP_IRQ_RETURN
    } csfr_op_t;

    typedef struct packed {
        csfr_op_t op;
        logic [7:0] addr;
        logic [7:0] imm;
        logic use_imm;
    } csfr_req_t;
endpackage
